// ===== hw/adcseq_pkg.sv
// constants, types and state layout of the conversion sequencer
// Overview of operation
// RULE1 - positive input select routes any single-ended source
// RULE2 - selections reach converter only once enabled
// RULE3 - clearing enable powers the core down
// RULE4 - ten-bit results stored right-justified
// RULE5 - start bit stays set, clears when done
// RULE6 - channel change waits for running conversion
// RULE7 - result from one sample or accumulation
// RULE8 - completion sets flag, interrupt needs both enables
// RULE9 - flag sets even with interrupt disabled
// RULE10 - enabled event input triggers a conversion
// RULE11 - event is edge sensitive, sets start bit
// RULE12 - free-running restarts right after each completion
// RULE13 - prescaler divides peripheral clock by select
// RULE14 - prescaler held at zero while disabled
// RULE15 - prescaler held reset between conversions
// RULE16 - start after half factor plus two cycles
// RULE17 - thirteen converter cycles, hold after two
// RULE18 - result stored, flag cleared by read/write-one
// RULE19 - sampling lasts two plus delay plus length
// RULE20 - free-run period thirteen plus delay plus length
// RULE21 - software configures first, sets enable last
// RULE22 - selections frozen during conversion, resume last cycle
// RULE23 - writing zero to start does nothing
// RULE24 - trigger during conversion is ignored
package adcseq_pkg;
   // field widths
   localparam int MUX_W    = 6;
   localparam int REF_W    = 3;
   localparam int DIV_W    = 3;
   localparam int ACC_W    = 3;
   localparam int DLY_W    = 4;
   localparam int LEN_W    = 8;
   localparam int PRE_W    = 8;
   localparam int CYC_W    = 9;
   localparam int SMP_W    = 7;
   localparam int RES_W    = 16;
   // timing counts in converter clock cycles
   localparam logic [CYC_W-1:0] CONV_CYCLES = 9'h00D;
   localparam logic [CYC_W-1:0] HOLD_CYCLE  = 9'h002;
   localparam logic [CYC_W-1:0] SAMP_BASE   = 9'h002;
   // start delay excess over half the prescale factor, in mclk
   localparam logic [PRE_W-1:0] START_EXTRA = 8'h02;
   // reset values and the accumulation limit
   localparam logic [REF_W-1:0] REF_RESET   = 3'h0; // internal reference
   localparam logic [MUX_W-1:0] MUX_RESET   = 6'h00;
   localparam logic [ACC_W-1:0] ACC_MAX     = 3'h6; // 64 samples

   // sequencer states, gray along idle-wait-convert
   typedef enum logic [1:0] {
      AS_IDLE = 2'b00,
      AS_WAIT = 2'b01,
      AS_CONV = 2'b11
   } adcseq_state_e;

   // whole state of the sequencer
   typedef struct packed {
      adcseq_state_e    st;
      logic [PRE_W-1:0] preCnt;
      logic [CYC_W-1:0] adcCnt;
      logic [SMP_W-1:0] smpCnt;
      logic [RES_W-1:0] acc;
      logic [RES_W-1:0] result;
      logic             startBit;
      logic             ready;
      logic             evPrev;
      logic [MUX_W-1:0] muxHeld;
      logic [REF_W-1:0] refHeld;
      logic             clkAdc;
      logic             holdPulse;
      logic             sampling;
      logic             irq;
   } adcseq_st_s;

   // converter-side signals bundled
   typedef struct packed {
      logic             powerUp;
      logic             clkAdc;
      logic             holdPulse;
      logic             sampling;
      logic [MUX_W-1:0] muxSel;
      logic [REF_W-1:0] reference_select;
   } adcseq_core_s;
endpackage

// ===== hw/adcseq_top.sv
// conversion sequencer: prescaler, triggers, timing, result and flag
`timescale 1ns/1ns
module adcseq_top
   import adcseq_pkg::*;
#(
   parameter int CORE_W = 10
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // configuration bits
   input  wire logic              converterEnable,
   input  wire logic              resolutionSelect,
   input  wire logic              continuousConversionEnable,
   input  wire logic [ACC_W-1:0]  accumulationCount,
   input  wire logic [REF_W-1:0]  referenceSelect,
   input  wire logic [DIV_W-1:0]  clockDividerSelect,
   input  wire logic [MUX_W-1:0]  positiveInputSelect,
   input  wire logic              startEventInputEnable,
   input  wire logic [DLY_W-1:0]  sampleDelay,
   input  wire logic [LEN_W-1:0]  sampleLength,
   input  wire logic              resultReadyIntEnable,
   input  wire logic              globalIntEnable,
   // software strobes
   input  wire logic              startConversionWrite,
   input  wire logic              resultReadyClearWrite,
   input  wire logic              resultRead,
   // event router
   input  wire logic              startEvent,
   // analog core
   input  wire logic [CORE_W-1:0] coreValue,
   output adcseq_core_s           coreCtrl,
   // status
   output logic                   startConversionBit,
   output logic                   resultReadyFlag,
   output logic [RES_W-1:0]       conversionResult,
   output logic                   interruptRequest
);

   // the accumulator must hold 64 full-scale samples
   if (CORE_W < 8 || CORE_W + 6 > RES_W) begin : g_badWidth
      $error("adcseq_top: CORE_W out of range");
   end

   adcseq_st_s q;
   adcseq_st_s d;

   // prescale factor is two to the power of select plus one
   function automatic logic [PRE_W-1:0] halfFactor(
      input logic [DIV_W-1:0] sel
   );
      logic [PRE_W-1:0] one;
      one = 8'h01;
      halfFactor = one << sel;
   endfunction

   // samples per result from the accumulation code
   function automatic logic [SMP_W-1:0] sampleTotal(
      input logic [ACC_W-1:0] code
   );
      logic [SMP_W-1:0] one;
      one = 7'h01;
      if (code > ACC_MAX) begin
         sampleTotal = one << ACC_MAX;
      end else begin
         sampleTotal = one << code;
      end
   endfunction

   logic [PRE_W-1:0] half;
   logic [PRE_W-1:0] factor;
   logic [CYC_W-1:0] sampEnd;
   logic [CYC_W-1:0] convEnd;
   logic [RES_W-1:0] sample;
   logic             evEdge;
   logic             trigger;
   logic             adcTick;
   logic             lastCycle;
   logic             readySet;

   // derived timing figures
   always_comb begin
      half    = halfFactor(clockDividerSelect);
      factor  = PRE_W'({half, 1'b0} - 9'h001);
      sampEnd = SAMP_BASE + CYC_W'(sampleDelay)
                + CYC_W'(sampleLength); // RULE19
      convEnd = CONV_CYCLES + CYC_W'(sampleDelay)
                + CYC_W'(sampleLength) - 9'h001; // RULE17 RULE20
      // low-resolution mode drops the two lowest bits
      if (resolutionSelect) begin
         sample = RES_W'(coreValue[CORE_W-1:2]);
      end else begin
         sample = RES_W'(coreValue); // RULE4
      end
   end

   // trigger qualification; only a one written or an enabled event edge starts anything
   assign evEdge    = startEvent & ~q.evPrev; // RULE11
   assign trigger   = converterEnable & (startConversionWrite
                      | (startEventInputEnable & evEdge)); // RULE10 RULE23
   assign adcTick   = (q.preCnt == factor);
   assign lastCycle = (q.st == AS_CONV) & (q.adcCnt == convEnd);

   // next-state logic
   always_comb begin
      d = q;
      readySet    = 1'b0;
      d.evPrev    = startEvent;
      d.holdPulse = 1'b0;
      unique case (q.st)
         AS_IDLE: begin
            d.preCnt = '0; // RULE15
            d.clkAdc = 1'b0;
            if (trigger) begin
               d.startBit = 1'b1; // RULE5 RULE11
               d.st       = AS_WAIT;
               d.smpCnt   = '0;
               d.acc      = '0;
            end
         end
         AS_WAIT: begin
            // start lands on the next converter clock rising edge
            if (q.preCnt == half + START_EXTRA - 8'h01) begin // RULE16
               d.st       = AS_CONV;
               d.preCnt   = '0;
               d.adcCnt   = '0;
               d.clkAdc   = 1'b1;
               d.sampling = 1'b1;
            end else begin
               d.preCnt = q.preCnt + 8'h01;
            end
         end
         AS_CONV: begin
            // ignored triggers keep timing untouched
            d.preCnt = adcTick ? '0 : q.preCnt + 8'h01; // RULE13 RULE24
            d.clkAdc = adcTick | (d.preCnt < half);
            if (adcTick) begin
               d.adcCnt   = q.adcCnt + 9'h001;
               d.holdPulse = (q.adcCnt + 9'h001 == HOLD_CYCLE); // RULE17
               d.sampling = (q.adcCnt + 9'h001 < sampEnd); // RULE19
               if (lastCycle) begin
                  d.acc    = q.acc + sample; // RULE7
                  d.smpCnt = q.smpCnt + 7'h01;
                  d.adcCnt = '0;
                  d.sampling = 1'b1;
                  if (q.smpCnt + 7'h01 == sampleTotal(accumulationCount)) begin
                     d.result = q.acc + sample; // RULE18
                     d.ready  = 1'b1; // RULE8 RULE9
                     readySet = 1'b1;
                     d.acc    = '0;
                     d.smpCnt = '0;
                     if (!continuousConversionEnable) begin
                        d.startBit = 1'b0; // RULE5
                        d.st       = AS_IDLE;
                        d.preCnt   = '0;
                        d.clkAdc   = 1'b0;
                        d.sampling = 1'b0;
                     end // RULE12 keeps converting
                  end
               end
            end
         end
         default: begin
            d.st = AS_IDLE;
         end
      endcase
      // clear loses to a set in the same cycle
      // a read racing a fresh result must not lose that result
      if ((resultRead | resultReadyClearWrite) && !readySet) begin
         d.ready = 1'b0; // RULE18
      end
      // selections track until a conversion runs, and in its last cycle
      if (converterEnable && (q.st != AS_CONV || lastCycle)) begin // RULE2
         d.muxHeld = positiveInputSelect; // RULE1 RULE6 RULE22
         d.refHeld = referenceSelect; // RULE22
      end
      // disable powers down and zeroes the prescaler
      if (!converterEnable) begin
         d.st        = AS_IDLE; // RULE3
         d.preCnt    = '0; // RULE14
         d.adcCnt    = '0;
         d.smpCnt    = '0;
         d.acc       = '0;
         d.startBit  = 1'b0;
         d.clkAdc    = 1'b0;
         d.sampling  = 1'b0;
         d.holdPulse = 1'b0;
      end
      d.irq = d.ready & resultReadyIntEnable & globalIntEnable; // RULE8
   end

   // state register
   always_ff @(posedge mclk) begin
      if (reset) begin
         q         <= '0;
         q.st      <= AS_IDLE;
         q.muxHeld <= MUX_RESET;
         q.refHeld <= REF_RESET;
      end else begin
         q <= d;
      end
   end

   // outputs from the state register, except powerUp, which follows converterEnable directly
   always_comb begin
      coreCtrl.powerUp   = converterEnable; // RULE3
      coreCtrl.clkAdc    = q.clkAdc;
      coreCtrl.holdPulse = q.holdPulse;
      coreCtrl.sampling  = q.sampling & (q.st == AS_CONV);
      coreCtrl.muxSel    = q.muxHeld;
      coreCtrl.reference_select    = q.refHeld;
   end

   assign startConversionBit = q.startBit;
   assign resultReadyFlag    = q.ready;
   assign conversionResult   = q.result;
   assign interruptRequest   = q.irq;

endmodule

// ===== tb/adcseq_asserts.sv
// port-level checks of the conversion sequencer
`timescale 1ns/1ns
module adcseq_asserts
   import adcseq_pkg::*;
(
   // clock and reset
   input wire logic             mclk,
   input wire logic             reset,
   // controls
   input wire logic             converterEnable,
   input wire logic [DIV_W-1:0] clockDividerSelect,
   input wire logic             startConversionWrite,
   input wire logic             resultRead,
   input wire logic             resultReadyIntEnable,
   input wire logic             globalIntEnable,
   // watched outputs
   input wire adcseq_core_s     coreCtrl,
   input wire logic             startConversionBit,
   input wire logic             resultReadyFlag,
   input wire logic             interruptRequest
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // power, start acceptance and start delay at the fastest divider
   property p_power; !converterEnable |-> !coreCtrl.powerUp
      ##1 (!coreCtrl.sampling && !coreCtrl.holdPulse); endproperty
   a_power: assert property (p_power) else $error("core power wrong");
   property p_start;
      converterEnable && startConversionWrite && !startConversionBit
         |=> startConversionBit;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_delay;
      $rose(startConversionBit) && clockDividerSelect == 3'h0
         |-> ##3 $rose(coreCtrl.clkAdc);
   endproperty
   a_delay: assert property (p_delay) else $error("start delay");
   property p_hold;
      $rose(coreCtrl.sampling) && clockDividerSelect == 3'h0
         && converterEnable ##1 converterEnable[*3]
         |-> ##1 coreCtrl.holdPulse;
   endproperty
   a_hold: assert property (p_hold) else $error("hold late");
   // completion, flag clearing and interrupt gating
   property p_done; $fell(startConversionBit) && converterEnable
      |-> resultReadyFlag; endproperty
   a_done: assert property (p_done) else $error("no flag at end");
   property p_clr; resultReadyFlag && resultRead && !startConversionBit
      |=> !resultReadyFlag; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_irq; interruptRequest == (resultReadyFlag
      && $past(resultReadyIntEnable) && $past(globalIntEnable)); endproperty
   a_irq: assert property (p_irq) else $error("irq not gated");
   // prescaler quiet when off or idle, selection frozen while sampling
   property p_off; !converterEnable
      |=> !startConversionBit && !coreCtrl.clkAdc; endproperty
   a_off: assert property (p_off) else $error("not held off");
   property p_idle; !startConversionBit && !$past(startConversionBit)
      |-> !coreCtrl.clkAdc; endproperty
   a_idle: assert property (p_idle) else $error("clock idle");
   property p_freeze; coreCtrl.sampling && $past(coreCtrl.sampling)
      |-> $stable(coreCtrl.muxSel); endproperty
   a_freeze: assert property (p_freeze) else $error("mux moved");
   c_done: cover property ($rose(resultReadyFlag));
   c_irq: cover property ($rose(interruptRequest));
   c_hold: cover property (coreCtrl.holdPulse);
endmodule
bind adcseq_top adcseq_asserts chk (.*);

// ===== tb/adcseq_core_model.sv
// behavioural analog core: sample follows the held channel
`timescale 1ns/1ns
module adcseq_core_model
   import adcseq_pkg::*;
(
   // clock and converter side
   input wire logic    mclk,
   input adcseq_core_s coreCtrl,
   output logic [9:0]  coreValue
);
   initial coreValue = 10'h155;
   // latch at hold; an unpowered core rotates so stale data never shows
   always @(posedge mclk) begin
      if (!coreCtrl.powerUp) coreValue <= {coreValue[8:0], ~coreValue[9]};
      else if (coreCtrl.holdPulse)
         coreValue <= {coreCtrl.muxSel, coreCtrl.reference_select, 1'b1};
   end
endmodule

// ===== tb/testbench.sv
// bench for the conversion sequencer with a behavioural core
`timescale 1ns/1ns
module testbench
   import adcseq_pkg::*;
;
   logic mclk, reset, converterEnable, resolutionSelect, startEvent;
   logic continuousConversionEnable, startEventInputEnable, resultRead;
   logic resultReadyIntEnable, globalIntEnable, startConversionWrite;
   logic resultReadyClearWrite, interruptRequest;
   logic startConversionBit, resultReadyFlag;
   logic [ACC_W-1:0] accumulationCount;
   logic [REF_W-1:0] referenceSelect;
   logic [DIV_W-1:0] clockDividerSelect;
   logic [MUX_W-1:0] positiveInputSelect;
   logic [DLY_W-1:0] sampleDelay;
   logic [LEN_W-1:0] sampleLength;
   logic [9:0]       coreValue;
   logic [RES_W-1:0] conversionResult, e;
   adcseq_core_s     coreCtrl;
   int bad_count = 0, n_checks = 0, cyc = 0, n, f;
   adcseq_top dut (.*);
   adcseq_core_model core (.*);
   // 40 ns clock and a hang guard
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 10000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle write of one to the start bit
   task automatic go();
      @(negedge mclk) startConversionWrite = 1;
      @(negedge mclk) startConversionWrite = 0;
   endtask
   task automatic rd();
      @(negedge mclk) resultRead = 1;
      @(negedge mclk) resultRead = 0;
   endtask
   // edges until the flag shows, bounded
   task automatic waitFlag();
      n = 0;
      while (resultReadyFlag !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      {converterEnable, resolutionSelect, continuousConversionEnable,
       accumulationCount, referenceSelect, clockDividerSelect,
       positiveInputSelect, startEventInputEnable, sampleDelay,
       sampleLength, resultReadyIntEnable, globalIntEnable,
       startConversionWrite, resultReadyClearWrite, resultRead,
       startEvent} = '0;
      reset = 1;
      repeat (4) @(negedge mclk);
      reset = 0;
      go();
      repeat (3) @(negedge mclk);
      chk(startConversionBit, 0);
      converterEnable = 1;
      // singles over dividers and sampling; channel moved mid-run
      for (int s = 0; s < 3; s++) begin
         clockDividerSelect = 3'(s);
         sampleDelay = 4'(s);
         sampleLength = 8'(2 * s);
         positiveInputSelect = 6'(5 + s);
         referenceSelect = 3'(s);
         e = 16'({positiveInputSelect, referenceSelect, 1'b1});
         f = 2 << s;
         go();
         repeat (3 * f) @(negedge mclk);
         positiveInputSelect = 6'h3f;
         waitFlag();
         chk(16'(n + 3 * f), 16'(f / 2 + 2 + (13 + 3 * s) * f));
         chk(conversionResult, e);
         chk(startConversionBit, 0);
         chk(interruptRequest, 0);
         rd();
         chk(resultReadyFlag, 0);
      end
      // four-sample sums; interrupt needs the global enable too
      {clockDividerSelect, sampleDelay, sampleLength, referenceSelect} = '0;
      positiveInputSelect = 6'h05;
      accumulationCount = 3'h2;
      resultReadyIntEnable = 1;
      for (int g = 0; g < 2; g++) begin
         globalIntEnable = g[0];
         go();
         waitFlag();
         chk(resultReadyFlag, 1);
         chk(conversionResult, 16'h0144);
         repeat (2) @(negedge mclk);
         chk(interruptRequest, g[0]);
         @(negedge mclk) resultReadyClearWrite = 1;
         @(negedge mclk) resultReadyClearWrite = 0;
         chk(resultReadyFlag, 0);
      end
      // events: ignored while the event input is disabled, one rising edge gives one conversion
      accumulationCount = '0;
      resolutionSelect = 1;
      startEvent = 1;
      repeat (3) @(negedge mclk);
      chk(startConversionBit, 0);
      startEvent = 0;
      @(negedge mclk) startEventInputEnable = 1;
      startEvent = 1;
      @(negedge mclk);
      waitFlag();
      chk(16'(n), 16'(1 + 2 + 13 * 2));
      chk(conversionResult, 16'h0014);
      rd();
      repeat (40) @(negedge mclk);
      chk(startConversionBit, 0);
      // free-running with a stray start write mid-conversion
      continuousConversionEnable = 1;
      startEvent = 0;
      go();
      waitFlag();
      @(negedge mclk) {resultRead, startConversionWrite} = 2'b11;
      @(negedge mclk) {resultRead, startConversionWrite} = 2'b00;
      waitFlag();
      chk(16'(n), 16'(13 * 2 - 1));
      chk(startConversionBit, 1);
      @(negedge mclk) converterEnable = 0;
      @(negedge mclk);
      chk(startConversionBit, 0);
      results();
   end
endmodule
